// [rtl/tcp_pkg.sv]
package tcp_pkg;

  localparam int TCP_NUM_TMR = 3;
  localparam int TCP_AW      = 12;
  localparam int TCP_DW      = 8;

  // control-two register of each timer
  localparam logic [2:0][11:0] TCP_CTL2_ADDR = {12'hF2A, 12'hF26, 12'hF22};
  // first pwm channel compare bytes, high then low, per timer
  localparam logic [2:0][11:0] TCP_CMPH_ADDR = {12'hF34, 12'hF32, 12'hF30};
  localparam logic [2:0][11:0] TCP_CMPL_ADDR = {12'hF35, 12'hF33, 12'hF31};

  // control-two field positions
  localparam int TCP_CLKSRC_BIT = 0;
  localparam int TCP_DUAL_BIT   = 4;
  localparam int TCP_DIRECT_BIT = 5;
  localparam logic [7:0] TCP_CTL2_MASK  = 8'h31;
  localparam logic [7:0] TCP_CTL2_RESET = 8'h00;
  localparam logic [7:0] TCP_CMP_RESET  = 8'h00;
  localparam logic [7:0] TCP_UNMAPPED   = 8'h00;

  localparam logic [3:0] TCP_MODE_DEMOD = 4'hC;

  // register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tcp_bus_t;

  // per-timer state from the counter core and first control register
  typedef struct packed {
    logic       run_enable;      // timer_run_enable
    logic [3:0] mode;            // timer_operating_mode
    logic       edge_polarity;   // input_edge_polarity, 0 rising
    logic       timer_in;        // timer input pin level
    logic       reload;          // counter reloads to 0001h this cycle
    logic       periph_tick;     // one cycle per peripheral clock period
  } tcp_tmr_in_t;

  // per-timer results toward the counter core
  typedef struct packed {
    logic        tick;           // timer clock enable
    logic        count_start;    // demodulation count trigger
    logic        capture;        // demodulation capture strobe
    logic [15:0] compare;        // active first pwm channel compare
  } tcp_tmr_out_t;

endpackage

// [rtl/tcp_clk_switch.sv]
module tcp_clk_switch
  import tcp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sel_req,
  input  wire logic periph_tick,
  output logic      tick_ff,
  output logic      sel_ff
);

  logic pending;

  assign pending = sel_req != sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // source change waits for a peripheral period boundary, so neither the
  // old nor the new source contributes a partial period
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_ff <= 1'b0;
    end else if (pending && periph_tick) begin
      sel_ff <= sel_req;
    end
  end

  // tick from the active source; while a change is pending it follows the peripheral tick
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_ff <= 1'b0;
    end else if (pending) begin
      tick_ff <= periph_tick;
    end else begin
      tick_ff <= sel_ff ? periph_tick : 1'b1;
    end
  end

  AST_SYS_TICK: assert property (@(posedge clk) disable iff (rst)
    (!rst && !sel_ff && !sel_req) |=> tick_ff)
    else $error("system clock source gave no tick");

  AST_NO_RUNT: assert property (@(posedge clk) disable iff (rst)
    (tick_ff && $past(sel_ff || sel_req)) |-> $past(periph_tick))
    else $error("runt tick while peripheral clock involved");

endmodule

// [rtl/tcp_timer_ctl2.sv]
// Implementation choice: strobed register access.
module tcp_timer_ctl2
  import tcp_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire tcp_bus_t                       bus_req,
  output logic [TCP_DW-1:0]                   rdata_ff,
  input  wire tcp_tmr_in_t [TCP_NUM_TMR-1:0]  tmr_in,
  output tcp_tmr_out_t [TCP_NUM_TMR-1:0]      tmr_out
);

  logic [TCP_NUM_TMR-1:0][7:0] ctl2_ff;
  logic [TCP_NUM_TMR-1:0][7:0] cmph_ff;
  logic [TCP_NUM_TMR-1:0][7:0] cmpl_ff;
  logic [TCP_DW-1:0]           nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; compare bytes read back the value last written
  always_comb begin
    nxt_rdata = TCP_UNMAPPED;
    for (int i = 0; i < TCP_NUM_TMR; i++) begin
      if (bus_req.addr == TCP_CTL2_ADDR[i]) begin
        nxt_rdata = ctl2_ff[i];
      end
      if (bus_req.addr == TCP_CMPH_ADDR[i]) begin
        nxt_rdata = cmph_ff[i];
      end
      if (bus_req.addr == TCP_CMPL_ADDR[i]) begin
        nxt_rdata = cmpl_ff[i];
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= TCP_UNMAPPED;
    end else if (bus_req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= TCP_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-timer logic
  for (genvar g = 0; g < TCP_NUM_TMR; g++) begin : g_tmr
    logic       wr_ctl2;
    logic       wr_cmph;
    logic       wr_cmpl;
    logic       direct;
    logic       dual_sel;
    logic       is_demod;
    logic       immediate;
    logic [7:0] nxt_cmph;
    logic [7:0] nxt_cmpl;
    logic [15:0] active_ff;
    logic       in_prev_ff;
    logic       counting_ff;
    logic       start_ff;
    logic       capture_ff;
    logic       rise;
    logic       fall;
    logic       any_edge;
    logic       single_hit;
    logic       cap_edge;

    assign wr_ctl2  = bus_req.wr && (bus_req.addr == TCP_CTL2_ADDR[g]);
    assign wr_cmph  = bus_req.wr && (bus_req.addr == TCP_CMPH_ADDR[g]);
    assign wr_cmpl  = bus_req.wr && (bus_req.addr == TCP_CMPL_ADDR[g]);
    assign direct   = ctl2_ff[g][TCP_DIRECT_BIT];
    assign is_demod = tmr_in[g].mode == TCP_MODE_DEMOD;
    // dual edge select is masked off outside demodulation
    assign dual_sel = is_demod && ctl2_ff[g][TCP_DUAL_BIT];
    // idle timer or direct update skips the buffer
    assign immediate = !tmr_in[g].run_enable || direct;

    // control-two: reserved bits are dropped and read as zero, so a
    // careless write of ones there cannot reach any logic
    always_ff @(posedge clk) begin
      if (rst) begin
        ctl2_ff[g] <= TCP_CTL2_RESET;
      end else if (wr_ctl2) begin
        ctl2_ff[g] <= bus_req.wdata & TCP_CTL2_MASK;
      end
    end

    // compare bytes as written, the buffer stage
    always_comb begin
      nxt_cmph = wr_cmph ? bus_req.wdata : cmph_ff[g];
      nxt_cmpl = wr_cmpl ? bus_req.wdata : cmpl_ff[g];
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cmph_ff[g] <= TCP_CMP_RESET;
        cmpl_ff[g] <= TCP_CMP_RESET;
      end else begin
        cmph_ff[g] <= nxt_cmph;
        cmpl_ff[g] <= nxt_cmpl;
      end
    end

    // active compare: a write in the reload cycle still makes that reload
    always_ff @(posedge clk) begin
      if (rst) begin
        active_ff <= {TCP_CMP_RESET, TCP_CMP_RESET};
      end else if (tmr_in[g].reload && tmr_in[g].run_enable) begin
        active_ff <= {nxt_cmph, nxt_cmpl};
      end else if (immediate) begin
        active_ff <= {nxt_cmph, nxt_cmpl};
      end
    end

    // input edge detection; the pin is already synchronous to clk
    always_ff @(posedge clk) begin
      if (rst) begin
        in_prev_ff <= 1'b0;
      end else begin
        in_prev_ff <= tmr_in[g].timer_in;
      end
    end

    assign rise       = tmr_in[g].timer_in && !in_prev_ff;
    assign fall       = !tmr_in[g].timer_in && in_prev_ff;
    assign any_edge   = rise || fall;
    // polarity 0 picks the rising edge, 1 the falling edge
    assign single_hit = tmr_in[g].edge_polarity ? fall : rise;
    assign cap_edge   = dual_sel ? any_edge : single_hit;

    // counting runs from the first qualifying edge until the timer stops or leaves demodulation
    always_ff @(posedge clk) begin
      if (rst) begin
        counting_ff <= 1'b0;
      end else if (!tmr_in[g].run_enable || !is_demod) begin
        counting_ff <= 1'b0;
      end else if (cap_edge) begin
        counting_ff <= 1'b1;
      end
    end

    // start strobe on the first edge, capture on each later one
    always_ff @(posedge clk) begin
      if (rst) begin
        start_ff   <= 1'b0;
        capture_ff <= 1'b0;
      end else begin
        start_ff   <= tmr_in[g].run_enable && is_demod && cap_edge
                      && !counting_ff;
        capture_ff <= tmr_in[g].run_enable && is_demod && cap_edge
                      && counting_ff;
      end
    end

    tcp_clk_switch u_clk_switch (
      .clk         (clk),
      .rst         (rst),
      .sel_req     (ctl2_ff[g][TCP_CLKSRC_BIT]),
      .periph_tick (tmr_in[g].periph_tick),
      .tick_ff     (tmr_out[g].tick),
      .sel_ff      ()
    );

    assign tmr_out[g].count_start = start_ff;
    assign tmr_out[g].capture     = capture_ff;
    assign tmr_out[g].compare     = active_ff;

    //////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_buffered_low_write;
      wr_cmpl && tmr_in[g].run_enable && !direct && !tmr_in[g].reload;
    endsequence

    sequence s_imm_low_write;
      wr_cmpl && immediate;
    endsequence

    AST_BUF_HOLD: assert property (@(posedge clk) disable iff (rst)
      s_buffered_low_write |=> (active_ff[7:0] == $past(active_ff[7:0])))
      else $error("buffered compare write took effect early");

    AST_BUF_APPLY: assert property (@(posedge clk) disable iff (rst)
      (tmr_in[g].reload && tmr_in[g].run_enable)
      |=> (active_ff == {cmph_ff[g], cmpl_ff[g]}))
      else $error("reload did not apply buffered compare");

    AST_IDLE_IMM: assert property (@(posedge clk) disable iff (rst)
      (wr_cmph && !tmr_in[g].run_enable)
      |=> (active_ff[15:8] == $past(bus_req.wdata)))
      else $error("idle timer compare write was delayed");

    AST_DIRECT_IMM: assert property (@(posedge clk) disable iff (rst)
      (s_imm_low_write and (direct && tmr_in[g].run_enable))
      |=> (active_ff[7:0] == $past(bus_req.wdata)))
      else $error("direct update compare write was delayed");

    AST_SINGLE_EDGE: assert property (@(posedge clk) disable iff (rst)
      (capture_ff && !$past(dual_sel))
      |-> $past(tmr_in[g].edge_polarity ? fall : rise))
      else $error("single edge capture on wrong edge");

    AST_DUAL_EDGE: assert property (@(posedge clk) disable iff (rst)
      (dual_sel && tmr_in[g].run_enable && counting_ff && any_edge)
      |=> capture_ff)
      else $error("dual edge mode missed a capture");

    AST_NON_DEMOD: assert property (@(posedge clk) disable iff (rst)
      !is_demod |=> (!capture_ff && !start_ff && !counting_ff))
      else $error("capture activity outside demodulation mode");
  end

endmodule

// [tb/timer_control2_clock_polarity_test.sv]
module timer_control2_clock_polarity_test
  import tcp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic                           clk;
  logic                           rst;
  tcp_bus_t                       bus_req;
  logic [7:0]                     rdata_ff;
  tcp_tmr_in_t [TCP_NUM_TMR-1:0]  tmr_in;
  tcp_tmr_out_t [TCP_NUM_TMR-1:0] tmr_out;
  int                             bad_count;
  int                             samples_checked;
  int                             cycles;
  int                             n_tick;
  int                             n_start;
  int                             n_cap;
  int                             t;
  logic [1:0]                     pdiv;

  tcp_timer_ctl2 tcp_timer_ctl2_i (
    .clk     (clk),
    .rst     (rst),
    .bus_req (bus_req),
    .rdata_ff(rdata_ff),
    .tmr_in  (tmr_in),
    .tmr_out (tmr_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // free-running clock, 5 ns period
  always #2.5 clk = ~clk;

  // peripheral clock every 4th cycle, event counters and hang guard
  always @(posedge clk) begin
    pdiv <= pdiv + 2'h1;
    tmr_in[0].periph_tick <= (pdiv == 2'h3);
    n_tick <= n_tick + int'(tmr_out[0].tick);
    n_start <= n_start + int'(tmr_out[0].count_start);
    n_cap <= n_cap + int'(tmr_out[0].capture);
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle write strobe, taken at the edge after it is raised
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input string what, input logic [11:0] a,
                    input logic [7:0] exp);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, {8'h00, rdata_ff}, {8'h00, exp});
  endtask

  // restart timer 0 in a mode, toggle its input n times, count pulses
  task automatic demod(input logic [7:0] c2, input logic [3:0] md,
                       input logic pol, input int n, input int es, ec);
    int s;
    int c;
    wr(TCP_CTL2_ADDR[0], c2);
    @(posedge clk);
    tmr_in[0].run_enable <= 1'b0;
    tmr_in[0].mode <= md;
    tmr_in[0].edge_polarity <= pol;
    cyc(3);
    @(posedge clk);
    tmr_in[0].run_enable <= 1'b1;
    cyc(3);
    s = n_start;
    c = n_cap;
    repeat (n) begin
      @(posedge clk);
      tmr_in[0].timer_in <= ~tmr_in[0].timer_in;
      cyc(5);
    end
    chk("count starts", 16'(n_start - s), 16'(es));
    chk("captures", 16'(n_cap - c), 16'(ec));
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    tmr_in = '0;
    pdiv = 2'h0;
    {bad_count, samples_checked, cycles, n_tick, n_start, n_cap} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reserved bits are dropped, so an all-ones write reads back the mask
    for (int i = 0; i < TCP_NUM_TMR; i++) begin
      rd("ctl2 reset", TCP_CTL2_ADDR[i], 8'h00);
      wr(TCP_CTL2_ADDR[i], 8'hFF);
      rd("ctl2 mask", TCP_CTL2_ADDR[i], 8'h31);
      // every timer's compare follows an idle write at once
      wr(TCP_CMPH_ADDR[i], 8'hA5);
      wr(TCP_CMPL_ADDR[i], 8'h5A);
      cyc(1);
      chk("compare idle each", tmr_out[i].compare, 16'hA55A);
    end
    rd("unmapped", 12'hF23, 8'h00);
    // idle timer: compare follows writes at once
    wr(TCP_CTL2_ADDR[0], 8'h00);
    wr(TCP_CMPH_ADDR[0], 8'h12);
    wr(TCP_CMPL_ADDR[0], 8'h34);
    cyc(2);
    chk("compare idle", tmr_out[0].compare, 16'h1234);
    // running, buffered: nothing moves until the reload pulse
    @(posedge clk);
    tmr_in[0].run_enable <= 1'b1;
    wr(TCP_CMPH_ADDR[0], 8'hAB);
    wr(TCP_CMPL_ADDR[0], 8'hCD);
    cyc(4);
    chk("compare held", tmr_out[0].compare, 16'h1234);
    rd("compare low", TCP_CMPL_ADDR[0], 8'hCD);
    @(posedge clk);
    tmr_in[0].reload <= 1'b1;
    @(posedge clk);
    tmr_in[0].reload <= 1'b0;
    cyc(1);
    chk("compare reload", tmr_out[0].compare, 16'hABCD);
    // direct update bypasses the buffer while running
    wr(TCP_CTL2_ADDR[0], 8'h20);
    wr(TCP_CMPL_ADDR[0], 8'h56);
    cyc(2);
    chk("compare direct", tmr_out[0].compare, 16'hAB56);
    // system clock ticks every cycle, peripheral one in four
    t = n_tick;
    cyc(20);
    chk("sys ticks", 16'(n_tick - t), 16'd20);
    wr(TCP_CTL2_ADDR[0], 8'h01);
    cyc(12);
    t = n_tick;
    cyc(40);
    chk("periph ticks", 16'(n_tick - t), 16'd10);
    wr(TCP_CTL2_ADDR[0], 8'h00);
    cyc(8);
    // demodulation: single edge, both polarities, dual edge, other mode
    demod(8'h00, 4'hC, 1'b0, 4, 1, 1);
    demod(8'h00, 4'hC, 1'b1, 3, 1, 0);
    demod(8'h10, 4'hC, 1'b0, 4, 1, 3);
    demod(8'h10, 4'h3, 1'b0, 4, 0, 0);
    end_of_test();
  end
endmodule
